// file: rtl/apsc_top.sv
// What this block does
// - Irq2 polarity: 1 high/rising, 0 low/falling
// - Swap A exchanges pin_p15 and pin_p35 functions
// - Swap B puts pin_p43 function on pin_p13
// - pin_p43 takes pin_p13 function only with oscillator
// - Bit 1 connects pull-up on pin_p11
// - Bit 0 connects pull-up on pin_p10
// - Default open-drain, no pull-up; bits independent
// - user_flag_two: plain storage bit, reset zero
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "apsc_regs.svh"

module apsc_top
   import apsc_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic resetn, // Synchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB byte strobes
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic int_osc_en, // Internal oscillator in use
   input wire logic gpio_p15_out, // Port function of pin_p15
   input wire logic gpio_p15_oe, // Its enable
   output logic gpio_p15_in, // Its input
   input wire logic gpio_p35_out, // Port function of pin_p35
   input wire logic gpio_p35_oe, // Its enable
   output logic timer_one_input, // Timer one count input
   input wire logic gpio_p13_out, // Port function of pin_p13
   input wire logic gpio_p13_oe, // Its enable
   output logic gpio_p13_in, // Its input
   input wire logic gpio_p43_out, // Port function of pin_p43
   input wire logic gpio_p43_oe, // Its enable
   output logic irq2_level, // Irq2 asserted level, registered
   output logic irq2_edge, // Irq2 active edge, one-cycle pulse
   input wire logic port_p10_low, // Port drives pin_p10 low
   output logic port_p10_in, // pin_p10 level to port
   input wire logic port_p11_low, // Port drives pin_p11 low
   output logic port_p11_in, // pin_p11 level to port
   input wire logic pin_p15_in, // Pin level
   output logic pin_p15_out, // Pin drive value
   output logic pin_p15_oe, // Pin drive enable
   input wire logic pin_p35_in, // Pin level
   output logic pin_p35_out, // Pin drive value
   output logic pin_p35_oe, // Pin drive enable
   input wire logic pin_p13_in, // Pin level
   output logic pin_p13_out, // Pin drive value
   output logic pin_p13_oe, // Pin drive enable
   input wire logic pin_p43_in, // Pin level
   output logic pin_p43_out, // Pin drive value
   output logic pin_p43_oe, // Pin drive enable
   input wire logic pin_p10_in, // Pin level
   output logic pin_p10_out, // Pin drive value
   output logic pin_p10_oe, // Pin drive enable
   output logic pin_p10_pullup, // Pull-up connected
   input wire logic pin_p11_in, // Pin level
   output logic pin_p11_out, // Pin drive value
   output logic pin_p11_oe, // Pin drive enable
   output logic pin_p11_pullup // Pull-up connected
);

   apsc_byte_t ctrl_ff;
   apsc_byte_t flags_ff;
   apsc_apb_e state_ff;
   logic [31:0] prdata_ff;
   logic hit_ctrl;
   logic hit_flags;
   logic setup;
   logic access;
   logic wr_en;
   logic irq2_src;
   logic irq2_act;
   logic irq2_prev_ff;
   logic irq2_level_ff;
   logic irq2_edge_ff;
   logic swap_a;
   logic swap_b;

   // Decode
   assign hit_ctrl = paddr == {`APSC_CTRL_IDX, 2'b00};
   assign hit_flags = paddr == {`APSC_FLAGS_IDX, 2'b00};
   assign setup = psel && !penable;
   // An access phase with no setup before it gets no answer
   assign access = psel && penable && state_ff == APSC_ACCESS;
   // Only lane 0 carries data; upper lanes hold nothing
   assign wr_en = access && pwrite && pstrb[0];

   // Zero wait states: read data is captured in the setup cycle
   assign pready = access;
   assign pslverr = access && !hit_ctrl && !hit_flags;
   assign prdata = prdata_ff;

   always_ff @(posedge clk)
   begin
      if (!resetn)
         state_ff <= APSC_IDLE;
      else
      begin
         case (state_ff)
            APSC_IDLE:
               if (setup)
                  state_ff <= APSC_ACCESS;
            APSC_ACCESS:
               if (!setup)
                  state_ff <= APSC_IDLE;
            default:
               state_ff <= APSC_IDLE;
         endcase
      end
   end

   // Reserved bits are never stored, so they always read zero
   always_ff @(posedge clk)
   begin
      if (!resetn)
         ctrl_ff <= `APSC_CTRL_RESET;
      else if (wr_en && hit_ctrl)
         ctrl_ff <= pwdata[7:0] & `APSC_CTRL_MASK;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         flags_ff <= `APSC_FLAGS_RESET;
      else if (wr_en && hit_flags)
         flags_ff <= pwdata[7:0] & `APSC_FLAGS_MASK;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         prdata_ff <= 32'h0000_0000;
      else if (setup && !pwrite)
      begin
         case (1'b1)
            hit_ctrl: prdata_ff <= {24'h00_0000, ctrl_ff};
            hit_flags: prdata_ff <= {24'h00_0000, flags_ff};
            default: prdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   assign swap_a = ctrl_ff[`APSC_SWAP_A_BIT];
   assign swap_b = ctrl_ff[`APSC_SWAP_B_BIT];

   // Pair A: timer one input follows pin_p35 function wherever it sits
   apsc_pin_swap u_swap_a (
      .en_a_to_b (swap_a),
      .en_b_to_a (swap_a),
      .fn_a_out (gpio_p15_out),
      .fn_a_oe (gpio_p15_oe),
      .fn_a_in (gpio_p15_in),
      .fn_b_out (gpio_p35_out),
      .fn_b_oe (gpio_p35_oe),
      .fn_b_in (timer_one_input),
      .pin_a_in (pin_p15_in),
      .pin_a_out (pin_p15_out),
      .pin_a_oe (pin_p15_oe),
      .pin_b_in (pin_p35_in),
      .pin_b_out (pin_p35_out),
      .pin_b_oe (pin_p35_oe)
   );

   // Pair B: pin_p43 is only free when the crystal input is unused
   apsc_pin_swap u_swap_b (
      .en_a_to_b (swap_b && int_osc_en),
      .en_b_to_a (swap_b),
      .fn_a_out (gpio_p13_out),
      .fn_a_oe (gpio_p13_oe),
      .fn_a_in (gpio_p13_in),
      .fn_b_out (gpio_p43_out),
      .fn_b_oe (gpio_p43_oe),
      .fn_b_in (irq2_src),
      .pin_a_in (pin_p13_in),
      .pin_a_out (pin_p13_out),
      .pin_a_oe (pin_p13_oe),
      .pin_b_in (pin_p43_in),
      .pin_b_out (pin_p43_out),
      .pin_b_oe (pin_p43_oe)
   );

   apsc_od_pullup u_pu_a (
      .pullup_en (ctrl_ff[`APSC_PU_A_BIT]),
      .drive_low (port_p10_low),
      .pin_in (pin_p10_in),
      .pin_out (pin_p10_out),
      .pin_oe (pin_p10_oe),
      .pullup_on (pin_p10_pullup),
      .port_in (port_p10_in)
   );

   apsc_od_pullup u_pu_b (
      .pullup_en (ctrl_ff[`APSC_PU_B_BIT]),
      .drive_low (port_p11_low),
      .pin_in (pin_p11_in),
      .pin_out (pin_p11_out),
      .pin_oe (pin_p11_oe),
      .pullup_on (pin_p11_pullup),
      .port_in (port_p11_in)
   );

   // Normalise polarity so downstream sees active high
   assign irq2_act = irq2_src ^ !ctrl_ff[`APSC_IRQ2_HIGH_BIT];

   // Prev starts at 1 so a pin already active at reset gives no edge
   always_ff @(posedge clk)
   begin
      if (!resetn)
         irq2_prev_ff <= 1'b1;
      else
         irq2_prev_ff <= irq2_act;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         irq2_level_ff <= 1'b0;
         irq2_edge_ff <= 1'b0;
      end
      else
      begin
         irq2_level_ff <= irq2_act;
         irq2_edge_ff <= irq2_act && !irq2_prev_ff;
      end
   end

   assign irq2_level = irq2_level_ff;
   assign irq2_edge = irq2_edge_ff;

   a_irq2_polarity: assert property (
      @(posedge clk) disable iff (!resetn)
      $past(resetn) |-> irq2_level == ($past(irq2_src)
         ^ !$past(ctrl_ff[`APSC_IRQ2_HIGH_BIT])))
      else $error("irq2 level does not follow selected polarity");

   a_irq2_edge_once: assert property (
      @(posedge clk) disable iff (!resetn)
      irq2_edge |=> !irq2_edge)
      else $error("irq2 edge pulse lasted more than one cycle");

   a_swap_a_timer: assert property (
      @(posedge clk) disable iff (!resetn)
      timer_one_input == (swap_a ? pin_p15_in : pin_p35_in))
      else $error("timer one input taken from wrong pin");

   a_swap_a_drive: assert property (
      @(posedge clk) disable iff (!resetn)
      swap_a |-> pin_p35_out == gpio_p15_out
         && pin_p15_oe == gpio_p35_oe)
      else $error("swap A pin drive not exchanged");

   a_swap_b_irq: assert property (
      @(posedge clk) disable iff (!resetn)
      irq2_src == (swap_b ? pin_p13_in : pin_p43_in))
      else $error("irq2 source taken from wrong pin");

   a_swap_b_drive: assert property (
      @(posedge clk) disable iff (!resetn)
      swap_b |-> pin_p13_out == gpio_p43_out
         && pin_p13_oe == gpio_p43_oe)
      else $error("pin_p13 does not carry the pin_p43 function");

   a_p43_osc_gate: assert property (
      @(posedge clk) disable iff (!resetn)
      (swap_b && !int_osc_en) |-> !pin_p43_oe)
      else $error("pin_p43 driven without internal oscillator");

   a_p43_osc_drive: assert property (
      @(posedge clk) disable iff (!resetn)
      (swap_b && int_osc_en) |-> pin_p43_out == gpio_p13_out
         && pin_p43_oe == gpio_p13_oe)
      else $error("pin_p43 does not carry the pin_p13 function");

   a_pullup_b_bit: assert property (
      @(posedge clk) disable iff (!resetn)
      (wr_en && hit_ctrl) |=> pin_p11_pullup
         == $past(pwdata[`APSC_PU_B_BIT]))
      else $error("pin_p11 pull-up does not follow written bit");

   a_pullup_a_bit: assert property (
      @(posedge clk) disable iff (!resetn)
      (wr_en && hit_ctrl) |=> pin_p10_pullup
         == $past(pwdata[`APSC_PU_A_BIT]))
      else $error("pin_p10 pull-up does not follow written bit");

   a_od_default: assert property (
      @(posedge clk)
      !resetn |=> !pin_p10_pullup && !pin_p11_pullup
         && !pin_p10_out && !pin_p11_out)
      else $error("open-drain pins not in default state after reset");

   a_od_drive_low: assert property (
      @(posedge clk) disable iff (!resetn)
      pin_p10_oe == port_p10_low && pin_p11_oe == port_p11_low)
      else $error("open-drain pin drive does not follow port request");

   // Write, one idle cycle, then a read setup of the same register
   a_flag_storage: assert property (
      @(posedge clk) disable iff (!resetn)
      (wr_en && hit_flags) ##2 (setup && !pwrite && hit_flags)
         |=> prdata[7:0] == ($past(pwdata[7:0], 3)
         & `APSC_FLAGS_MASK))
      else $error("user flag does not read back as written");

   a_flag_reserved: assert property (
      @(posedge clk) disable iff (!resetn)
      (flags_ff & ~`APSC_FLAGS_MASK) == 8'h00)
      else $error("reserved flag bits hold a value");

endmodule

// file: rtl/apsc_regs.svh
`ifndef APSC_REGS_SVH
`define APSC_REGS_SVH

// Register indices; byte address is four times the index
`define APSC_CTRL_IDX 10'h08e
`define APSC_FLAGS_IDX 10'h0a2

// aux_pin_control fields
`define APSC_IRQ2_HIGH_BIT 6
`define APSC_SWAP_A_BIT 5
`define APSC_SWAP_B_BIT 3
`define APSC_PU_B_BIT 1
`define APSC_PU_A_BIT 0
`define APSC_CTRL_MASK 8'h6b
`define APSC_CTRL_RESET 8'h00

// aux_user_flags fields
`define APSC_FLAG2_BIT 3
`define APSC_FLAGS_MASK 8'h08
`define APSC_FLAGS_RESET 8'h00

`endif

// file: rtl/apsc_pkg.sv
package apsc_pkg;

   typedef logic [7:0] apsc_byte_t;

   typedef enum logic [0:0] {
      APSC_IDLE,
      APSC_ACCESS
   } apsc_apb_e;

endpackage

// file: rtl/apsc_pin_swap.sv
`timescale 1ns/1ps

// Exchanges the functions of two pins; each direction enabled on its own
module apsc_pin_swap (
   input wire logic en_a_to_b, // Function A moves to pin B
   input wire logic en_b_to_a, // Function B moves to pin A
   input wire logic fn_a_out, // Function A output value
   input wire logic fn_a_oe, // Function A output enable
   output logic fn_a_in, // Function A input value
   input wire logic fn_b_out, // Function B output value
   input wire logic fn_b_oe, // Function B output enable
   output logic fn_b_in, // Function B input value
   input wire logic pin_a_in, // Pin A level
   output logic pin_a_out, // Pin A drive value
   output logic pin_a_oe, // Pin A drive enable
   input wire logic pin_b_in, // Pin B level
   output logic pin_b_out, // Pin B drive value
   output logic pin_b_oe // Pin B drive enable
);

   always_comb
   begin
      // A pin that lost its function and gained none stays undriven
      pin_a_out = 1'b0;
      pin_a_oe = 1'b0;
      if (en_b_to_a)
      begin
         pin_a_out = fn_b_out;
         pin_a_oe = fn_b_oe;
      end
      else if (!en_a_to_b)
      begin
         pin_a_out = fn_a_out;
         pin_a_oe = fn_a_oe;
      end
   end

   always_comb
   begin
      pin_b_out = 1'b0;
      pin_b_oe = 1'b0;
      if (en_a_to_b)
      begin
         pin_b_out = fn_a_out;
         pin_b_oe = fn_a_oe;
      end
      else if (!en_b_to_a)
      begin
         pin_b_out = fn_b_out;
         pin_b_oe = fn_b_oe;
      end
   end

   assign fn_a_in = en_a_to_b ? pin_b_in : pin_a_in;
   assign fn_b_in = en_b_to_a ? pin_a_in : pin_b_in;

endmodule

// file: rtl/apsc_od_pullup.sv
`timescale 1ns/1ps

// Open-drain pin: drives low only, optional pull-up
module apsc_od_pullup (
   input wire logic pullup_en, // Pull-up enable bit
   input wire logic drive_low, // Port asks the pin low
   input wire logic pin_in, // Pin level
   output logic pin_out, // Pin drive value
   output logic pin_oe, // Pin drive enable
   output logic pullup_on, // Pull-up resistor connected
   output logic port_in // Level back to the port
);

   // N-channel only: never drives high
   assign pin_out = 1'b0;
   assign pin_oe = drive_low;
   assign pullup_on = pullup_en;
   assign port_in = pin_in;

endmodule

// file: bench/apsc_top_test.sv
`timescale 1ns/1ps
`include "apsc_regs.svh"

module apsc_top_test;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, int_osc_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic err;
   logic gpio_p15_out, gpio_p15_oe, gpio_p15_in, gpio_p35_out, gpio_p35_oe;
   logic timer_one_input, gpio_p13_out, gpio_p13_oe, gpio_p13_in;
   logic gpio_p43_out, gpio_p43_oe, irq2_level, irq2_edge;
   logic port_p10_low, port_p10_in, port_p11_low, port_p11_in;
   logic pin_p15_in, pin_p15_out, pin_p15_oe, pin_p35_in, pin_p35_out;
   logic pin_p35_oe, pin_p13_in, pin_p13_out, pin_p13_oe;
   logic pin_p43_in, pin_p43_out, pin_p43_oe;
   logic pin_p10_in, pin_p10_out, pin_p10_oe, pin_p10_pullup;
   logic pin_p11_in, pin_p11_out, pin_p11_oe, pin_p11_pullup;
   int num_errors = 0;
   int samples_checked = 0;
   localparam logic [11:0] CTRL_ADDR = {`APSC_CTRL_IDX, 2'b00};
   localparam logic [11:0] FLAG_ADDR = {`APSC_FLAGS_IDX, 2'b00};
   localparam logic [7:0] BITV [5] = '{8'h40, 8'h20, 8'h08, 8'h02, 8'h01};
   // Rows: ctrl, oscillator, expected pins, mask of known pins
   localparam logic [7:0] SW_CTRL [5] = '{8'h00, 8'h20, 8'h08, 8'h08, 8'h28};
   localparam logic SW_OSC [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
   localparam logic [9:0] SW_EXP [5] = '{10'h32c, 10'h0dc, 10'h320, 10'h323,
      10'h0d3};
   localparam logic [9:0] SW_MSK [5] = '{10'h3ff, 10'h3ff, 10'h3fe, 10'h3ff,
      10'h3ff};

   apsc_top apsc_top_inst (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .int_osc_en(int_osc_en), .gpio_p15_out(gpio_p15_out),
      .gpio_p15_oe(gpio_p15_oe), .gpio_p15_in(gpio_p15_in),
      .gpio_p35_out(gpio_p35_out), .gpio_p35_oe(gpio_p35_oe),
      .timer_one_input(timer_one_input), .gpio_p13_out(gpio_p13_out),
      .gpio_p13_oe(gpio_p13_oe), .gpio_p13_in(gpio_p13_in),
      .gpio_p43_out(gpio_p43_out), .gpio_p43_oe(gpio_p43_oe),
      .irq2_level(irq2_level), .irq2_edge(irq2_edge),
      .port_p10_low(port_p10_low), .port_p10_in(port_p10_in),
      .port_p11_low(port_p11_low), .port_p11_in(port_p11_in),
      .pin_p15_in(pin_p15_in), .pin_p15_out(pin_p15_out),
      .pin_p15_oe(pin_p15_oe), .pin_p35_in(pin_p35_in),
      .pin_p35_out(pin_p35_out), .pin_p35_oe(pin_p35_oe),
      .pin_p13_in(pin_p13_in), .pin_p13_out(pin_p13_out),
      .pin_p13_oe(pin_p13_oe), .pin_p43_in(pin_p43_in),
      .pin_p43_out(pin_p43_out), .pin_p43_oe(pin_p43_oe),
      .pin_p10_in(pin_p10_in), .pin_p10_out(pin_p10_out),
      .pin_p10_oe(pin_p10_oe), .pin_p10_pullup(pin_p10_pullup),
      .pin_p11_in(pin_p11_in), .pin_p11_out(pin_p11_out),
      .pin_p11_oe(pin_p11_oe), .pin_p11_pullup(pin_p11_pullup));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp,
      input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Entered just after a rising edge; waits one edge so release never
   // collides with the next setup
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // No cycle budget here; only the watchdog ends a hung wait
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1);
      chk("pready", 32'h1, pready);
      chk("ready wait", 32'h1, n);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string name, input logic [11:0] a,
      input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(name, exp, rd);
      chk("pslverr", 32'h0, err);
   endtask

   task automatic irq_chk(input logic [1:0] e1, input logic [1:0] e2);
      repeat (2) @(posedge clk);
      chk("irq2 level/edge", e1, {irq2_level, irq2_edge});
      @(posedge clk);
      chk("irq2 after pulse", e2, {irq2_level, irq2_edge});
   endtask

   initial
   begin
      repeat (3000) @(posedge clk);
      num_errors++;
      $display("CHECK FAILED watchdog expected finish seen hang");
      end_sim();
   end

   initial
   begin
      {resetn, psel, penable, pwrite, paddr, pwdata, int_osc_en} = '0;
      pstrb = 4'hf;
      {gpio_p15_out, gpio_p15_oe, gpio_p35_out, gpio_p35_oe} = 4'b1100;
      {gpio_p13_out, gpio_p13_oe, gpio_p43_out, gpio_p43_oe} = 4'b1100;
      {pin_p15_in, pin_p35_in, pin_p13_in, pin_p43_in} = 4'b0101;
      {port_p10_low, port_p11_low, pin_p10_in, pin_p11_in} = 4'b0000;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rdchk("ctrl reset", CTRL_ADDR, 32'h0);
      rdchk("flags reset", FLAG_ADDR, 32'h0);
      chk("pullups reset", 32'h0,
         {pin_p11_pullup, pin_p10_pullup});
      // Reserved control bits are always written as zero
      apb(1'b1, CTRL_ADDR, 32'h6b);
      rdchk("ctrl writable", CTRL_ADDR, 32'h6b);
      apb(1'b1, FLAG_ADDR, 32'h7f);
      rdchk("flags reserved", FLAG_ADDR, 32'h08);
      apb(1'b1, FLAG_ADDR, 32'h0);
      rdchk("flag clear", FLAG_ADDR, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b1, CTRL_ADDR, {24'h0, BITV[i]});
         rdchk("ctrl bit", CTRL_ADDR, {24'h0, BITV[i]});
         chk("pullups", BITV[i][1:0],
            {pin_p11_pullup, pin_p10_pullup});
      end
      pstrb <= 4'h0;
      apb(1'b1, CTRL_ADDR, 32'h40);
      pstrb <= 4'hf;
      rdchk("strobe off", CTRL_ADDR, 32'h01);
      apb(1'b1, 12'h004, 32'hff);
      chk("unmapped err", 32'h1, err);
      apb(1'b0, 12'h000, 32'h0);
      chk("unmapped err", 32'h1, err);
      chk("unmapped data", 32'h0, rd);
      rdchk("ctrl kept", CTRL_ADDR, 32'h01);
      // Only pin_p10 pulled up; pin_p10 asked low, pin_p11 floats in
      {port_p10_low, pin_p11_in} <= 2'b11;
      @(posedge clk);
      chk("p10 drive", 32'h4,
         {pin_p10_oe, pin_p10_out, port_p10_in});
      chk("p11 idle", 32'h1,
         {pin_p11_oe, pin_p11_out, port_p11_in});
      for (int i = 0; i < 5; i++)
      begin
         int_osc_en <= SW_OSC[i];
         apb(1'b1, CTRL_ADDR, {24'h0, SW_CTRL[i]});
         @(posedge clk);
         chk("pin swaps", SW_EXP[i] & SW_MSK[i], SW_MSK[i] & {pin_p15_out,
            pin_p15_oe, pin_p35_out, pin_p35_oe, timer_one_input,
            gpio_p15_in, pin_p13_out, pin_p13_oe, pin_p43_oe,
            gpio_p13_in});
         // gpio_p13 drives 1, seen on pin_p43 only when it is freed
         chk("p43 carries p13", SW_CTRL[i][3] & SW_OSC[i],
            pin_p43_out);
      end
      int_osc_en <= 1'b0;
      apb(1'b1, CTRL_ADDR, 32'h0);
      irq_chk(2'b00, 2'b00);
      pin_p43_in <= 1'b0;
      irq_chk(2'b11, 2'b10);
      pin_p43_in <= 1'b1;
      irq_chk(2'b00, 2'b00);
      apb(1'b1, CTRL_ADDR, 32'h40);
      pin_p43_in <= 1'b0;
      irq_chk(2'b00, 2'b00);
      pin_p43_in <= 1'b1;
      irq_chk(2'b11, 2'b10);
      // With swap B the interrupt follows pin_p13
      apb(1'b1, CTRL_ADDR, 32'h48);
      irq_chk(2'b00, 2'b00);
      pin_p13_in <= 1'b1;
      irq_chk(2'b11, 2'b10);
      apb(1'b1, FLAG_ADDR, 32'h08);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rdchk("flag reset", FLAG_ADDR, 32'h0);
      rdchk("ctrl reset", CTRL_ADDR, 32'h0);
      end_sim();
   end
endmodule
